// file: tlp_core_model.sv
// Behavioural model of the core's program counter and return stack.
// Assumes vector load and stack push are one-cycle pulses on clk_i.
`timescale 1ns/1ps

module tlp_core_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // From the controller
  input  wire logic        load_i,
  input  wire logic        push_i,
  input  wire logic [15:0] vec_i,
  // From the bench
  input  wire logic        ret_req_i,
  // To the controller and the bench
  output logic             ret_o,
  output logic [3:0]       depth_o,
  output logic [15:0]      pc_o
);
  // --------------------------------------------------------------------
  // Stack depth and program counter
  // --------------------------------------------------------------------
  // Depth follows push and return only, so a load without push shows as imbalance
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      depth_o <= 4'h0;
    end else if (push_i) begin
      depth_o <= depth_o + 4'h1;
    end else if (ret_o) begin
      depth_o <= depth_o - 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o <= 16'h0000;
    end else if (load_i) begin
      pc_o <= vec_i;
    end
  end

  // Return pulse one cycle after the bench asks for it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ret_o <= 1'b0;
    end else begin
      ret_o <= ret_req_i;
    end
  end
endmodule : tlp_core_model

// file: tlp_irq_ctrl.sv
// Two-level priority interrupt controller with Avalon-MM registers.
// Assumes event inputs are one-cycle pulses synchronous to MCLK_I and that
// the core loads its program counter on VECTOR_LOAD_O.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "tlp_irq_params.svh"

module tlp_irq_ctrl #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  // Clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  NRST_I,
  // Avalon-MM slave
  input  wire logic [13:0]           AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [31:0]           AVS_WRITEDATA_I,
  input  wire logic [3:0]            AVS_BYTEENABLE_I,
  output logic      [31:0]           AVS_READDATA_O,
  output logic                       AVS_WAITREQUEST_O,
  // Interrupt events
  input  wire logic [7:0]            PERIPH_EVENT_I,
  input  wire logic                  TIMER0_EVENT_I,
  input  wire logic                  EXT_PIN_EVENT_I,
  input  wire logic                  PORT_CHANGE_EVENT_I,
  // Core program counter and stack
  input  wire logic                  RETURN_FROM_IRQ_I,
  output logic                       VECTOR_LOAD_O,
  output logic                       STACK_PUSH_O,
  output tlp_irq_pkg::tlp_addr_t     VECTOR_ADDR_O
);
  import tlp_irq_pkg::*;

  // --------------------------------------------------------------------
  // Registers and decode
  // --------------------------------------------------------------------
  tlp_byte_t  irq_en1;
  tlp_byte_t  pir1;
  tlp_byte_t  ipr1;
  tlp_byte_t  cipr;
  tlp_byte_t  main_ctl;
  tlp_byte_t  rst_ctl;
  logic       hi_active;
  logic       lo_active;
  logic       ack;
  tlp_state_e state;
  logic [1:0] wait_cnt;

  logic [11:0] idx;
  logic        req_on;
  logic        wr_en;
  tlp_byte_t   wdata;
  tlp_byte_t   rd_mux;
  tlp_byte_t   en1_mask;

  assign idx       = AVS_ADDRESS_I[13:2];
  assign req_on    = AVS_READ_I | AVS_WRITE_I;
  assign wr_en     = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0];
  assign wdata     = AVS_WRITEDATA_I[7:0];
  // Port enable is absent on the small package
  assign en1_mask  = LARGE_PACKAGE ? 8'hff : 8'h7f;

  // One wait state: answer in the second cycle of every request
  assign AVS_WAITREQUEST_O = req_on & ~ack;

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ack <= 1'b0;
    end else begin
      ack <= req_on & ~ack;
    end
  end

  always_comb begin
    case (idx)
      `TLP_IDX_EN1:     rd_mux = irq_en1 & en1_mask;
      `TLP_IDX_PIR1:    rd_mux = pir1;
      `TLP_IDX_IPR1:    rd_mux = ipr1;
      `TLP_IDX_CIPR:    rd_mux = cipr & 8'h07;
      `TLP_IDX_MAINCTL: rd_mux = main_ctl;
      `TLP_IDX_RSTCTL:  rd_mux = rst_ctl;
      `TLP_IDX_STAT:    rd_mux = {6'h00, hi_active, lo_active};
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (AVS_READ_I & ~ack) begin
      AVS_READDATA_O <= {24'h00_0000, rd_mux};
    end
  end

  // --------------------------------------------------------------------
  // Enable, priority and mode registers
  // --------------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_en1 <= `TLP_RST_EN1;
      ipr1    <= `TLP_RST_IPR1;
      cipr    <= `TLP_RST_CIPR;
      rst_ctl <= `TLP_RST_RSTCTL;
    end else if (wr_en) begin
      if (idx == `TLP_IDX_EN1) irq_en1 <= wdata & en1_mask;
      if (idx == `TLP_IDX_IPR1) ipr1 <= wdata;
      if (idx == `TLP_IDX_CIPR) cipr <= wdata & 8'h07;
      if (idx == `TLP_IDX_RSTCTL) rst_ctl <= wdata & 8'h80;
    end
  end

  // --------------------------------------------------------------------
  // Request evaluation
  // --------------------------------------------------------------------
  logic       prio_mode;
  logic       hlge;
  logic       llge;
  logic [2:0] core_flag;
  logic [2:0] core_act;
  tlp_byte_t  peri_act;
  logic       hi_src;
  logic       lo_src;
  logic       hi_req;
  logic       lo_req;
  logic       cmp_req;
  logic       req;
  logic       take;
  logic       take_hi;

  assign prio_mode = rst_ctl[`TLP_BIT_PMODE];
  assign hlge      = main_ctl[`TLP_BIT_HLGE];
  assign llge      = main_ctl[`TLP_BIT_LLGE];
  assign core_flag = main_ctl[2:0];
  assign core_act  = main_ctl[5:3] & core_flag;
  assign peri_act  = pir1 & irq_en1 & en1_mask;
  assign hi_src    = |(core_act & cipr[2:0]) | |(peri_act & ipr1);
  assign lo_src    = |(core_act & ~cipr[2:0]) | |(peri_act & ~ipr1);
  assign hi_req    = prio_mode & hlge & hi_src;
  // Low level waits for both enables and for no high routine
  assign lo_req    = prio_mode & hlge & llge & lo_src &
                     ~hi_active;
  // Priority bits play no part here
  assign cmp_req   = ~prio_mode & hlge &
                     (|core_act | (llge & |peri_act));
  assign req       = hi_req | lo_req | cmp_req;

  // --------------------------------------------------------------------
  // Fixed-latency acceptance
  // --------------------------------------------------------------------
  // Fixed count instead of instruction boundaries keeps the latency
  // equal for one- and two-cycle instructions.
  assign take    = (state == S_WAIT) & req &
                   (wait_cnt == `TLP_LAT_CYC - 2'd2);
  assign take_hi = hi_req | cmp_req;

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state    <= S_IDLE;
      wait_cnt <= 2'd0;
    end else begin
      case (state)
        S_IDLE: begin
          wait_cnt <= 2'd0;
          if (req) state <= S_WAIT;
        end
        S_WAIT: begin
          wait_cnt <= wait_cnt + 2'd1;
          // A request withdrawn by software is dropped
          if (!req || take) state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      VECTOR_LOAD_O <= 1'b0;
      STACK_PUSH_O  <= 1'b0;
      VECTOR_ADDR_O <= `TLP_VEC_HIGH;
    end else begin
      VECTOR_LOAD_O <= take;
      STACK_PUSH_O  <= take;
      if (take) begin
        VECTOR_ADDR_O <= take_hi ? `TLP_VEC_HIGH :
                         `TLP_VEC_LOW;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hi_active <= 1'b0;
      lo_active <= 1'b0;
    end else if (take) begin
      if (take_hi) hi_active <= 1'b1;
      else lo_active <= 1'b1;
    end else if (RETURN_FROM_IRQ_I) begin
      if (hi_active) hi_active <= 1'b0;
      else lo_active <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Flags and global enables
  // --------------------------------------------------------------------
  // Event sets win over a software clear in the same cycle.
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pir1 <= `TLP_RST_PIR1;
    end else if (wr_en && idx == `TLP_IDX_PIR1) begin
      pir1 <= wdata | PERIPH_EVENT_I;
    end else begin
      pir1 <= pir1 | PERIPH_EVENT_I;
    end
  end

  tlp_byte_t next_main_ctl;
  always_comb begin
    next_main_ctl = main_ctl;
    if (wr_en && idx == `TLP_IDX_MAINCTL) next_main_ctl = wdata;
    next_main_ctl[2:0] = next_main_ctl[2:0] |
      {TIMER0_EVENT_I, EXT_PIN_EVENT_I, PORT_CHANGE_EVENT_I};
    if (take) begin
      // Acceptance beats a concurrent software set of the enable
      if (take_hi) next_main_ctl[`TLP_BIT_HLGE] = 1'b0;
      else next_main_ctl[`TLP_BIT_LLGE] = 1'b0;
    end else if (RETURN_FROM_IRQ_I) begin
      if (hi_active || !lo_active) begin
        next_main_ctl[`TLP_BIT_HLGE] = 1'b1;
      end else begin
        next_main_ctl[`TLP_BIT_LLGE] = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      main_ctl <= `TLP_RST_MAINCTL;
    end else begin
      main_ctl <= next_main_ctl;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_vec_high;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && prio_mode && hi_req |=> VECTOR_LOAD_O &&
      VECTOR_ADDR_O == `TLP_VEC_HIGH;
  endproperty
  a_vec_high: assert property (p_vec_high)
    else $error("high request not vectored to high address");

  property p_vec_low;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && prio_mode && !hi_req |=> VECTOR_ADDR_O == `TLP_VEC_LOW;
  endproperty
  a_vec_low: assert property (p_vec_low)
    else $error("low request not vectored to low address");

  property p_low_held;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && hi_active |-> take_hi;
  endproperty
  a_low_held: assert property (p_low_held)
    else $error("low request taken during high routine");

  property p_low_gate;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && prio_mode && !take_hi |-> hlge && llge;
  endproperty
  a_low_gate: assert property (p_low_gate)
    else $error("low request taken without both enables");

  property p_compat_vec;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && !prio_mode |=> VECTOR_ADDR_O == `TLP_VEC_HIGH;
  endproperty
  a_compat_vec: assert property (p_compat_vec)
    else $error("compatibility interrupt not at single vector");

  property p_peri_gate;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && !prio_mode && core_act == 3'b000 |-> llge && hlge;
  endproperty
  a_peri_gate: assert property (p_peri_gate)
    else $error("peripheral taken with gate clear");

  property p_clear_enable;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && take_hi |=> !hlge ##1 1'b1;
  endproperty
  a_clear_enable: assert property (p_clear_enable)
    else $error("global enable not cleared on acceptance");

  property p_push_load;
    @(posedge MCLK_I) disable iff (!NRST_I)
    STACK_PUSH_O == VECTOR_LOAD_O;
  endproperty
  a_push_load: assert property (p_push_load)
    else $error("stack push and vector load disagree");

  property p_return;
    @(posedge MCLK_I) disable iff (!NRST_I)
    RETURN_FROM_IRQ_I && !take && !lo_active |=> hlge;
  endproperty
  a_return: assert property (p_return)
    else $error("return did not set global enable");

  property p_latency;
    @(posedge MCLK_I) disable iff (!NRST_I)
    (state == S_IDLE && req) ##1 req ##1 req |=> VECTOR_LOAD_O;
  endproperty
  a_latency: assert property (p_latency)
    else $error("acceptance latency wrong");

  property p_flag_set;
    @(posedge MCLK_I) disable iff (!NRST_I)
    |PERIPH_EVENT_I |=> (pir1 & $past(PERIPH_EVENT_I)) ==
      $past(PERIPH_EVENT_I);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event flag not set");

  property p_flag_hold;
    @(posedge MCLK_I) disable iff (!NRST_I)
    !(wr_en && idx == `TLP_IDX_PIR1) |=> (pir1 & $past(pir1)) ==
      $past(pir1);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag cleared without software write");

  property p_high_first;
    @(posedge MCLK_I) disable iff (!NRST_I)
    take && hi_req && lo_req |-> take_hi;
  endproperty
  a_high_first: assert property (p_high_first)
    else $error("low taken ahead of high");

  property p_small_pkg;
    @(posedge MCLK_I) disable iff (!NRST_I)
    !LARGE_PACKAGE |-> !irq_en1[`TLP_BIT_PORT];
  endproperty
  a_small_pkg: assert property (p_small_pkg)
    else $error("port enable set on small package");

endmodule : tlp_irq_ctrl

// file: tlp_irq_params.svh
// Constants of the two-level priority interrupt controller.
// Assumes a 20 MHz instruction clock and an Avalon-MM byte-addressed bus.
// Operation
// - Priority mode vectors high requests to 0008h, low to 0018h.
// - High request preempts low routine; low held off in high routine.
// - Every source has an event flag, an enable and a priority select.
// - Priority mode only when reset-control bit 7 is set; resets clear.
// - Priority mode: high global enable admits high-priority sources.
// - Low-priority sources need both high and low global enables set.
// - Flag, enable and global enable set vector at once by priority.
// - Priority-mode bit clear selects compatibility; priority ignored.
// - Compatibility: bit 6 gates peripherals, bit 7 gates everything.
// - Compatibility mode takes every interrupt to vector 0008h.
// - Taking an interrupt clears the global enable of its level.
// - Taking an interrupt pushes the return address and loads the vector.
// - Return-from-interrupt sets the global enable of its level again; here a return in the same cycle as an acceptance is ignored.
// - Pin and port-change latency is three to four instruction cycles.
// - Flags set on events whatever the individual or global enables.
// - Compatibility: peripheral gate must be set for peripheral irqs.
// - Peripheral enable 1 bits 7..0: port, A/D, rx, tx, sync, ccp, t2, t1.
// - Parallel-port enable bit reads zero on the small package.
`ifndef TLP_IRQ_PARAMS_SVH
`define TLP_IRQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TLP_IDX_EN1     12'hf9d
`define TLP_IDX_PIR1    12'hf9e
`define TLP_IDX_IPR1    12'hf9f
`define TLP_IDX_STAT    12'hfa0
`define TLP_IDX_CIPR    12'hff1
`define TLP_IDX_MAINCTL 12'hff2
`define TLP_IDX_RSTCTL  12'hfd0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TLP_RST_EN1     8'h00
`define TLP_RST_PIR1    8'h00
`define TLP_RST_IPR1    8'hff
`define TLP_RST_CIPR    8'h07
`define TLP_RST_MAINCTL 8'h00
`define TLP_RST_RSTCTL  8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TLP_BIT_HLGE   7
`define TLP_BIT_LLGE   6
`define TLP_BIT_PMODE  7
`define TLP_BIT_PORT   7

// ----------------------------------------------------------------------
// Vectors and timing
// ----------------------------------------------------------------------
`define TLP_VEC_HIGH   16'h0008
`define TLP_VEC_LOW    16'h0018
`define TLP_LAT_CYC    2'd3

`endif

// file: tlp_irq_pkg.sv
// Types shared by the interrupt controller.
// Assumes nothing beyond a SystemVerilog compiler.
package tlp_irq_pkg;
  typedef logic [7:0]  tlp_byte_t;
  typedef logic [15:0] tlp_addr_t;
  typedef enum logic {S_IDLE, S_WAIT} tlp_state_e;
endpackage : tlp_irq_pkg

// file: tlp_irq_tb.sv
// Self-checking bench of the interrupt controller and core model.
// Assumes one wait state per bus access as the controller provides.
`timescale 1ns/1ps
`include "tlp_irq_params.svh"

module testbench;
  import tlp_irq_pkg::*;
  // --------------------------------------------------------------------
  // Signals and scoreboard
  // --------------------------------------------------------------------
  logic        mclk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [13:0] addr = 14'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  be = 4'h1;
  logic        wait_req, ret, ret_req = 1'b0, vload, vpush;
  logic [7:0]  pev = 8'h00;
  logic [2:0]  ext = 3'b000;
  logic [3:0]  depth;
  logic [15:0] pc;
  tlp_addr_t   vaddr;
  tlp_byte_t   rq[$];
  tlp_addr_t   vq[$];
  int          lq[$];
  int          cyc = 0, err_total = 0, n_tests = 0, l;
  logic [31:0] rv;

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  tlp_irq_ctrl tlp_irq_ctrl_inst (
    .MCLK_I(mclk), .NRST_I(nrst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
    .PERIPH_EVENT_I(pev), .TIMER0_EVENT_I(ext[2]), .EXT_PIN_EVENT_I(ext[1]),
    .PORT_CHANGE_EVENT_I(ext[0]), .RETURN_FROM_IRQ_I(ret),
    .VECTOR_LOAD_O(vload), .STACK_PUSH_O(vpush), .VECTOR_ADDR_O(vaddr));

  tlp_core_model tlp_core_model_inst (
    .clk_i(mclk), .rst_n_i(nrst), .load_i(vload), .push_i(vpush),
    .vec_i(vaddr), .ret_req_i(ret_req), .ret_o(ret), .depth_o(depth),
    .pc_o(pc));

  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Bus access; for a read d is the expected byte
  task automatic av(input bit w, input logic [11:0] idx, input tlp_byte_t d);
    int n;
    n = 0;
    if (!w) rq.push_back(d);
    @(posedge mclk);
    addr <= {idx, 2'b00};
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) chk("bus answer", 0, 1);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av

  // One-cycle event pulse; latency is checked when v is nonzero
  task automatic ev(input logic [7:0] p, input logic [2:0] x,
                    input tlp_addr_t v);
    @(posedge mclk);
    if (v !== 16'h0) begin
      vq.push_back(v);
      lq.push_back(cyc + 5);
    end
    pev <= p;
    ext <= x;
    @(posedge mclk);
    pev <= 8'h00;
    ext <= 3'b000;
  endtask : ev

  task automatic rti;
    @(posedge mclk);
    ret_req <= 1'b1;
    @(posedge mclk);
    ret_req <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : rti

  // --------------------------------------------------------------------
  // Monitor: results against the oldest note
  // --------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rd && wait_req === 1'b0) begin
      chk("readdata", {24'h0, rq.pop_front()}, rdata);
    end
    if (vload === 1'b1) begin
      if (vq.size() == 0) chk("unexpected vector", 0, 1);
      else begin
        chk("vector", vq.pop_front(), vaddr);
        chk("stack push", 1, vpush);
        l = lq.pop_front();
        if (l != 0) chk("latency", l, cyc);
      end
    end
  end

  initial begin
    #200000;
    err_total++;
    end_of_test;
  end

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(75846));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    av(0, `TLP_IDX_EN1, `TLP_RST_EN1);
    av(0, `TLP_IDX_PIR1, `TLP_RST_PIR1);
    av(0, `TLP_IDX_IPR1, `TLP_RST_IPR1);
    av(0, `TLP_IDX_CIPR, `TLP_RST_CIPR);
    av(0, `TLP_IDX_MAINCTL, `TLP_RST_MAINCTL);
    av(0, `TLP_IDX_RSTCTL, `TLP_RST_RSTCTL);
    av(0, 12'h123, 8'h00);
    rv = $urandom;
    av(1, `TLP_IDX_EN1, rv[7:0]);
    av(0, `TLP_IDX_EN1, rv[7:0]);
    be <= 4'h0;
    av(1, `TLP_IDX_EN1, 8'hff);
    be <= 4'h1;
    av(0, `TLP_IDX_EN1, rv[7:0]);
    // Compatibility mode, low priority bits ignored
    av(1, `TLP_IDX_IPR1, 8'h00);
    av(1, `TLP_IDX_EN1, 8'h01);
    ev(8'h01, 3'b000, 16'h0);
    repeat (4) @(posedge mclk);
    av(0, `TLP_IDX_PIR1, 8'h01);
    av(1, `TLP_IDX_MAINCTL, 8'h80);
    repeat (8) @(posedge mclk);
    av(0, `TLP_IDX_PIR1, 8'h01);
    vq.push_back(`TLP_VEC_HIGH);
    lq.push_back(0);
    av(1, `TLP_IDX_MAINCTL, 8'hc0);
    repeat (8) @(posedge mclk);
    av(0, `TLP_IDX_MAINCTL, 8'h40);
    av(1, `TLP_IDX_PIR1, 8'h00);
    rti;
    av(0, `TLP_IDX_MAINCTL, 8'hc0);
    // External pin latency
    av(1, `TLP_IDX_MAINCTL, 8'h90);
    ev(8'h00, 3'b010, `TLP_VEC_HIGH);
    repeat (8) @(posedge mclk);
    av(0, `TLP_IDX_MAINCTL, 8'h12);
    av(1, `TLP_IDX_MAINCTL, 8'h10);
    rti;
    av(0, `TLP_IDX_MAINCTL, 8'h90);
    // Port-change latency
    av(1, `TLP_IDX_MAINCTL, 8'h88);
    ev(8'h00, 3'b001, `TLP_VEC_HIGH);
    repeat (8) @(posedge mclk);
    av(0, `TLP_IDX_MAINCTL, 8'h09);
    av(1, `TLP_IDX_MAINCTL, 8'h08);
    rti;
    av(0, `TLP_IDX_MAINCTL, 8'h88);
    av(1, `TLP_IDX_MAINCTL, 8'h00);
    // Timer event flags with every MAINCTL enable clear; EN1 bit 0 is still set
    ev(8'h00, 3'b100, 16'h0);
    av(0, `TLP_IDX_MAINCTL, 8'h04);
    av(1, `TLP_IDX_MAINCTL, 8'h00);
    // Priority mode: simultaneous, hold-off, preemption
    av(1, `TLP_IDX_RSTCTL, 8'h80);
    av(1, `TLP_IDX_IPR1, 8'h01);
    av(1, `TLP_IDX_EN1, 8'h03);
    av(1, `TLP_IDX_MAINCTL, 8'h80);
    ev(8'h03, 3'b000, `TLP_VEC_HIGH);
    repeat (8) @(posedge mclk);
    av(0, `TLP_IDX_MAINCTL, 8'h00);
    av(0, `TLP_IDX_STAT, 8'h02);
    av(1, `TLP_IDX_PIR1, 8'h02);
    av(1, `TLP_IDX_MAINCTL, 8'hc0);
    repeat (8) @(posedge mclk);
    vq.push_back(`TLP_VEC_LOW);
    lq.push_back(0);
    rti;
    repeat (4) @(posedge mclk);
    av(0, `TLP_IDX_MAINCTL, 8'h80);
    ev(8'h01, 3'b000, `TLP_VEC_HIGH);
    repeat (8) @(posedge mclk);
    av(0, `TLP_IDX_STAT, 8'h03);
    av(1, `TLP_IDX_PIR1, 8'h00);
    rti;
    rti;
    av(0, `TLP_IDX_MAINCTL, 8'hc0);
    av(0, `TLP_IDX_STAT, 8'h00);
    chk("stack depth", 0, {28'h0, depth});
    chk("pending vectors", 0, vq.size());
    end_of_test;
  end
endmodule : testbench
